// [logic/eftc_defs.svh]
// Constants for the frame timestamp capture unit
`ifndef EFTC_DEFS_SVH
`define EFTC_DEFS_SVH
`define EFTC_TS_W 32
`define EFTC_TAG_W 4
`define EFTC_STAT_W 8
`define EFTC_STAT_REQ_BIT 5
`define EFTC_FLAG_W 2
`define EFTC_FLAG_AVAIL 0
`define EFTC_FLAG_WRAP 1
`define EFTC_TIMER_RESET 32'h0000_0000
`define EFTC_FLAG_RESET 2'h0
`endif

// [logic/eftc_pkg.sv]
// Types for the frame timestamp capture unit
package eftc_pkg;
	typedef logic [31:0] eftc_ts_t;
	typedef logic [3:0] eftc_tag_t;
	typedef logic [1:0] eftc_flag_t;
endpackage

// [logic/eftc_timer.sv]
// Free-running capture timer shared by both directions
`timescale 1ns/1ps
`include "eftc_defs.svh"
module eftc_timer (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic run_i,
	output eftc_pkg::eftc_ts_t count_o,
	output logic wrap_o
);
	import eftc_pkg::*;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			count_o <= `EFTC_TIMER_RESET;
		end else if (run_i) begin
			count_o <= count_o + 32'h0000_0001;
		end
	end
	assign wrap_o = run_i && (count_o == 32'hffff_ffff);
endmodule // eftc_timer

// [logic/eftc_capture.sv]
// Transmit and receive timestamp capture unit
// Summary of operation
// - Timestamp support works only while precision time enable is one.
// - Every transmitted frame returns capture value, sequence tag and status.
// - Status bit 5 set when capture request came with the frame.
// - Requested frames also store their capture in the held register.
// - Storing a requested capture sets the capture available flag.
// - Unrequested frames touch neither held register nor available flag.
// - Every received frame latches the timer at delimiter detection.
// - Flags clear by writing one; zero ignored; reset clears all.
// - Interrupt raised when a set flag meets its set mask bit.
`timescale 1ns/1ps
`include "eftc_defs.svh"
module eftc_capture (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic precision_time_enable_i,
	input wire logic tx_frame_start_i,
	input wire logic tx_capture_request_i,
	input wire eftc_pkg::eftc_tag_t tx_frame_tag_i,
	input wire logic rx_sfd_detect_i,
	input wire eftc_pkg::eftc_flag_t event_flag_clear_i,
	input wire eftc_pkg::eftc_flag_t event_mask_reg_i,
	output eftc_pkg::eftc_ts_t tx_capture_value_o,
	output eftc_pkg::eftc_tag_t tx_frame_sequence_tag_o,
	output logic [`EFTC_STAT_W-1:0] tx_capture_requested_status_o,
	output logic tx_capture_valid_o,
	output eftc_pkg::eftc_ts_t held_tx_capture_o,
	output eftc_pkg::eftc_ts_t rx_capture_value_o,
	output logic rx_capture_valid_o,
	output eftc_pkg::eftc_flag_t event_flag_reg_o,
	output logic irq_o,
	output eftc_pkg::eftc_ts_t timer_o
);
	import eftc_pkg::*;
	eftc_ts_t now;
	logic wrap;
	logic tx_take;
	logic rx_take;
	logic store;
	eftc_flag_t flag_set;
	// ********************
	// Shared timer
	// ********************
	// shared timer
	eftc_timer u_timer (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.run_i(precision_time_enable_i),
		.count_o(now),
		.wrap_o(wrap)
	);
	assign timer_o = now;
	assign tx_take = precision_time_enable_i && tx_frame_start_i;
	assign rx_take = precision_time_enable_i && rx_sfd_detect_i;
	assign store = tx_take && tx_capture_request_i;
	// ********************
	// Status word
	// ********************
	// Only the request bit carries meaning, so spare bits can never leak old state
	function automatic logic [`EFTC_STAT_W-1:0] status_word(input logic req);
		logic [`EFTC_STAT_W-1:0] word;
		word = {`EFTC_STAT_W{1'b0}};
		word[`EFTC_STAT_REQ_BIT] = req;
		return word;
	endfunction
	// ********************
	// Transmit return
	// ********************
	// per-frame return
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_capture_value_o <= `EFTC_TIMER_RESET;
			tx_frame_sequence_tag_o <= 4'h0;
			tx_capture_requested_status_o <= 8'h00;
			tx_capture_valid_o <= 1'b0;
		end else begin
			tx_capture_valid_o <= tx_take;
			if (tx_take) begin
				tx_capture_value_o <= now;
				tx_frame_sequence_tag_o <= tx_frame_tag_i;
				tx_capture_requested_status_o <= status_word(tx_capture_request_i);
			end
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			held_tx_capture_o <= `EFTC_TIMER_RESET;
		end else if (store) begin
			held_tx_capture_o <= now;
		end
	end
	// ********************
	// Receive capture
	// ********************
	// latch at delimiter
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rx_capture_value_o <= `EFTC_TIMER_RESET;
			rx_capture_valid_o <= 1'b0;
		end else begin
			rx_capture_valid_o <= rx_take;
			if (rx_take) begin
				rx_capture_value_o <= now;
			end
		end
	end
	// ********************
	// Event flags
	// ********************
	always_comb begin
		flag_set = 2'h0;
		flag_set[`EFTC_FLAG_AVAIL] = store;
		flag_set[`EFTC_FLAG_WRAP] = wrap;
	end
	// write one clears
	// Set beats clear so a capture landing on a clear is not lost
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			event_flag_reg_o <= `EFTC_FLAG_RESET;
		end else begin
			event_flag_reg_o <= (event_flag_reg_o & ~event_flag_clear_i) | flag_set;
		end
	end
	assign irq_o = |(event_flag_reg_o & event_mask_reg_i);
	// ********************
	// Transmit checks
	// ********************
	// Every check is disabled across reset, which is asynchronous and may come mid-run
	sequence s_req_frame;
		precision_time_enable_i && tx_frame_start_i && tx_capture_request_i;
	endsequence
	sequence s_stored;
		##1 event_flag_reg_o[`EFTC_FLAG_AVAIL] && held_tx_capture_o == $past(now);
	endsequence
	sequence s_plain_frame;
		precision_time_enable_i && tx_frame_start_i && !tx_capture_request_i;
	endsequence
	sequence s_held_kept;
		##1 $stable(held_tx_capture_o);
	endsequence
	a_tx_hold_store: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_req_frame |-> s_stored) else $error("requested capture not held");
	a_tx_return: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_take |=> tx_capture_valid_o && tx_capture_value_o == $past(now)
		&& tx_frame_sequence_tag_o == $past(tx_frame_tag_i)) else $error("tx return wrong");
	a_tx_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!tx_take |=> !tx_capture_valid_o && $stable(tx_capture_value_o) && $stable(tx_frame_sequence_tag_o))
		else $error("tx return changed without frame");
	a_tx_status: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_take |=> tx_capture_requested_status_o[`EFTC_STAT_REQ_BIT] == $past(tx_capture_request_i))
		else $error("tx status bit wrong");
	a_status_rest: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_capture_valid_o |-> tx_capture_requested_status_o[7:6] == 2'h0
		&& tx_capture_requested_status_o[4:0] == 5'h0) else $error("tx status spare bits set");
	a_hold_stable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!store |=> $stable(held_tx_capture_o)) else $error("held capture changed");
	a_plain_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_plain_frame |-> s_held_kept) else $error("plain frame moved held capture");
	a_plain_no_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_plain_frame ##0 !event_flag_reg_o[`EFTC_FLAG_AVAIL] |=> !event_flag_reg_o[`EFTC_FLAG_AVAIL])
		else $error("plain frame set available flag");
	// ********************
	// Enable checks
	// ********************
	// no flag while disabled
	a_disabled_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!precision_time_enable_i && !event_flag_reg_o[0] |=> !event_flag_reg_o[0])
		else $error("flag set while disabled");
	a_disabled_held: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!precision_time_enable_i |=> $stable(held_tx_capture_o))
		else $error("held capture moved while disabled");
	a_disabled_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!precision_time_enable_i |=> !tx_capture_valid_o && !rx_capture_valid_o)
		else $error("capture while disabled");
	a_timer_run: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		precision_time_enable_i |=> timer_o == $past(timer_o) + 32'h1) else $error("timer stuck");
	a_timer_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!precision_time_enable_i |=> $stable(timer_o)) else $error("timer moved while disabled");
	// ********************
	// Receive checks
	// ********************
	// latch at delimiter
	a_rx_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		rx_take |=> rx_capture_valid_o && rx_capture_value_o == $past(now))
		else $error("rx capture wrong");
	a_rx_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!rx_take |=> !rx_capture_valid_o && $stable(rx_capture_value_o))
		else $error("rx capture changed without delimiter");
	a_shared_timer: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_take && rx_take |=> tx_capture_value_o == rx_capture_value_o)
		else $error("tx and rx captures differ");
	// ********************
	// Flag checks
	// ********************
	// write one clears
	a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		event_flag_reg_o[0] && event_flag_clear_i[0] && !store |=> !event_flag_reg_o[0])
		else $error("flag not cleared");
	a_flag_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		event_flag_reg_o[0] && !event_flag_clear_i[0] |=> event_flag_reg_o[0])
		else $error("flag lost");
	a_flag_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!event_flag_reg_o[0] && !store |=> !event_flag_reg_o[0])
		else $error("flag set from nothing");
	a_irq_mask: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		irq_o == |(event_flag_reg_o & event_mask_reg_i)) else $error("irq mismatch");
	a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(event_flag_reg_o[`EFTC_FLAG_AVAIL]) && event_mask_reg_i[`EFTC_FLAG_AVAIL] |-> irq_o)
		else $error("interrupt missed on new flag");
endmodule // eftc_capture

// [verif/eftc_client.sv]
// Transmit client and receive DMA stand-in
`timescale 1ns/1ps
module eftc_client (
	input wire logic clk_sys_i,
	input wire logic send_i,
	input wire logic want_i,
	input wire eftc_pkg::eftc_tag_t tag_i,
	input wire logic recv_i,
	input wire eftc_pkg::eftc_ts_t rx_capture_value_i,
	input wire logic rx_capture_valid_i,
	output logic tx_frame_start_o,
	output logic tx_capture_request_o,
	output eftc_pkg::eftc_tag_t tx_frame_tag_o,
	output logic rx_sfd_detect_o,
	output eftc_pkg::eftc_ts_t descriptor_o
);
	import eftc_pkg::*;
	always_ff @(posedge clk_sys_i) begin
		tx_frame_start_o <= send_i;
		// Qualifiers churn between frames so a stale sample shows
		tx_capture_request_o <= send_i ? want_i : ~tx_capture_request_o;
		tx_frame_tag_o <= send_i ? tag_i : ~tx_frame_tag_o;
		rx_sfd_detect_o <= recv_i;
	end
	always_ff @(posedge clk_sys_i) begin
		if (rx_capture_valid_i) begin
			descriptor_o <= rx_capture_value_i;
		end
	end
endmodule // eftc_client

// [verif/eftc_capture_test.sv]
// Random traffic bench for the capture unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module eftc_capture_test;
	import eftc_pkg::*;
	logic clk_sys_i, reset_i, en, send, want, recv, st, rq, sfd, tv, rv, fl, dv = 0;
	eftc_tag_t tag, tg, tge;
	eftc_flag_t clr, mask, flg;
	eftc_ts_t cnt, txe, held, rxe, desc, dsc, txo, hld, rxo, tmr;
	logic [7:0] ste, sto;
	logic txv, rxv, irq;
	logic fw;
	eftc_tag_t tgx;
	function automatic logic [7:0] exp_status(input logic req);
		return {2'h0, req, 5'h0};
	endfunction
	function automatic logic exp_irq(input eftc_flag_t f, input eftc_flag_t m);
		return |(f & m);
	endfunction
	int errors = 0;
	int n_compared = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	eftc_client i_eftc_client (.clk_sys_i(clk_sys_i), .send_i(send), .want_i(want), .tag_i(tag), .recv_i(recv),
		.rx_capture_value_i(rxo), .rx_capture_valid_i(rxv), .tx_frame_start_o(st), .tx_capture_request_o(rq),
		.tx_frame_tag_o(tg), .rx_sfd_detect_o(sfd), .descriptor_o(dsc));
	eftc_capture i_eftc_capture (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .precision_time_enable_i(en),
		.tx_frame_start_i(st), .tx_capture_request_i(rq), .tx_frame_tag_i(tg), .rx_sfd_detect_i(sfd),
		.event_flag_clear_i(clr), .event_mask_reg_i(mask), .tx_capture_value_o(txo), .tx_frame_sequence_tag_o(tge),
		.tx_capture_requested_status_o(sto), .tx_capture_valid_o(txv), .held_tx_capture_o(hld),
		.rx_capture_value_o(rxo), .rx_capture_valid_o(rxv), .event_flag_reg_o(flg), .irq_o(irq), .timer_o(tmr));
	// ************
	// Reference model
	// ************
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			{cnt, txe, held, rxe, ste, tv, rv, fl, fw, tgx} <= '0;
		end else begin
			tv <= en & st;
			rv <= en & sfd;
			cnt <= en ? cnt + 32'h1 : cnt;
			if (en & st) begin
				txe <= cnt;
				ste <= exp_status(rq);
				tgx <= tg;
				held <= rq ? cnt : held;
			end
			rxe <= (en & sfd) ? cnt : rxe;
			fl <= (en & st & rq) | (fl & ~clr[0]);
			fw <= (en && cnt == 32'hffff_ffff) | (fw & ~clr[1]);
		end
	end
	always @(posedge clk_sys_i) begin
		if (rv) begin
			desc <= rxe;
			dv <= 1'b1;
		end
	end
	// ************
	// Comparisons
	// ************
	always @(negedge clk_sys_i) begin
		`CHK("tx_valid", tv, txv)
		`CHK("tx_value", txe, txo)
		`CHK("tx_status", ste, sto)
		`CHK("tx_tag", tgx, tge)
		`CHK("held", held, hld)
		if (clr[0] && flg[0]) `CHK("held_read", held, hld)
		`CHK("flags", {fw, fl}, flg)
		`CHK("irq", exp_irq({fw, fl}, mask), irq)
		`CHK("rx_valid", rv, rxv)
		`CHK("rx_value", rxe, rxo)
		`CHK("timer", cnt, tmr)
		if (dv) `CHK("descriptor", desc, dsc)
	end
	task automatic complete_run;
		if (errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		{clk_sys_i, en, send, want, tag, recv, clr, mask} = '0;
		reset_i = 1'b1;
		void'($urandom(52));
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Disabled stretches and a mid-run reset among back-to-back frames
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_sys_i);
			en <= (i % 500) > 60;
			// Corner: a requested frame whose store meets a clear of both flags
			send <= (i % 250 == 100) || 1'($urandom);
			want <= (i % 250 == 100) || 1'($urandom);
			tag <= 4'($urandom);
			recv <= 1'($urandom);
			clr <= (i % 250 == 101) ? 2'h3 :
				{1'($urandom % 5 == 0), 1'((flg[0] || $urandom % 9 == 0) && $urandom % 3 == 0)};
			mask <= 2'($urandom);
			reset_i <= (i == 1500);
		end
		complete_run;
	end
endmodule // eftc_capture_test
